// File: rtl/ledd_ctrl.sv
// Display controller: AXI4-Lite registers driving the serial chain.
`timescale 1ns/1ps
module ledd_ctrl #(
	parameter int CHAIN = 1, // Devices in the chain.
	parameter int HALF  = 4  // Serial clock half period in cycles.
) (
	input  wire logic                        aclk,    // Clock.
	input  wire logic                        aresetn, // Reset, low.
	input  wire logic                        ce,      // Clock enable.
	input  wire logic [ledd_pkg::ADDR_W-1:0] awaddr,  // Write address.
	input  wire logic                        awvalid, // Address valid.
	output logic                             awready, // Address ready.
	input  wire logic [31:0]                 wdata,   // Write data.
	input  wire logic [3:0]                  wstrb,   // Byte strobes.
	input  wire logic                        wvalid,  // Data valid.
	output logic                             wready,  // Data ready.
	output logic      [1:0]                  bresp,   // Write response.
	output logic                             bvalid,  // Response valid.
	input  wire logic                        bready,  // Response ready.
	input  wire logic [ledd_pkg::ADDR_W-1:0] araddr,  // Read address.
	input  wire logic                        arvalid, // Address valid.
	output logic                             arready, // Address ready.
	output logic      [31:0]                 rdata,   // Read data.
	output logic      [1:0]                  rresp,   // Read response.
	output logic                             rvalid,  // Read valid.
	input  wire logic                        rready,  // Read ready.
	ledd_if.ctrl                             link     // Chain pins.
);
	import ledd_pkg::*;

	localparam int BITS = CH * CHAIN;
	localparam int BW   = $clog2(BITS + 1);
	localparam logic [BW-1:0] LAST_BIT = BW'(BITS - 1);
	localparam logic [7:0] HALF_END  = 8'(HALF - 1);
	localparam logic [7:0] PHASE_END = 8'(2 * HALF - 1);
	localparam logic [7:0] OEN_END   = 8'(OEN_CYC + SYNC_LAT - 1);

	// The return path needs two sync flops plus the far end's latency.
	if (CHAIN < 1 || HALF < 3 || 2 * HALF > 255)
		$error("ledd_ctrl: CHAIN or HALF out of range");

	// ------------------------------------------------------------
	// AXI4-Lite slave and registers
	// ------------------------------------------------------------
	logic          awg_q, awg_d, wg_q, wg_d;
	logic [3:0]    adr_q, adr_d;
	logic [31:0]   wd_q, wd_d;
	logic [3:0]    ws_q, ws_d;
	logic          awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
	logic          arr_q, arr_d, rv_q, rv_d;
	logic [31:0]   rd_q, rd_d;
	logic [CH-1:0] data_q, data_d;
	logic [3:0]    ctl_q, ctl_d;
	logic [CH-1:0] rx_q;
	ledd_cst_t     st_q;
	logic          wr;
	logic          go;
	assign wr = awg_q & wg_q & ~bv_q;
	assign go = wr & (adr_q == REG_CTRL) & ws_q[0] & (st_q == C_IDLE);

	// Address and data are taken in either order; the write acts once.
	always_comb begin
		awg_d  = awg_q | (awvalid & awr_q);
		wg_d   = wg_q | (wvalid & wr_q);
		adr_d  = (awvalid & awr_q) ? awaddr : adr_q;
		wd_d   = (wvalid & wr_q) ? wdata : wd_q;
		ws_d   = (wvalid & wr_q) ? wstrb : ws_q;
		bv_d   = bv_q & ~bready;
		data_d = data_q;
		ctl_d  = ctl_q;
		if (wr) begin
			awg_d = 1'b0;
			wg_d  = 1'b0;
			bv_d  = 1'b1;
			if (adr_q == REG_DATA && ws_q[0])
				data_d[7:0] = wd_q[7:0];
			if (adr_q == REG_DATA && ws_q[1])
				data_d[15:8] = wd_q[15:8];
			if (go)
				ctl_d = wd_q[3:0];
		end
		awr_d = ~awg_d & ~bv_d;
		wr_d  = ~wg_d & ~bv_d;
		rv_d  = rv_q & ~rready;
		rd_d  = rd_q;
		if (arvalid && arr_q) begin
			rv_d = 1'b1;
			case (araddr)
				REG_CTRL:   rd_d = {28'h0000000, ctl_q};
				REG_DATA:   rd_d = {16'h0000, data_q};
				REG_STATUS: rd_d = {31'h00000000, st_q != C_IDLE};
				REG_RX:     rd_d = {16'h0000, rx_q};
				default:    rd_d = 32'h00000000;
			endcase
		end
		arr_d = ~rv_d;
	end

	// Registers of the bus slave.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awg_q  <= 1'b0;
			wg_q   <= 1'b0;
			adr_q  <= '0;
			wd_q   <= '0;
			ws_q   <= '0;
			awr_q  <= 1'b0;
			wr_q   <= 1'b0;
			bv_q   <= 1'b0;
			arr_q  <= 1'b0;
			rv_q   <= 1'b0;
			rd_q   <= '0;
			data_q <= '0;
			ctl_q  <= '0;
		end else if (ce) begin
			awg_q  <= awg_d;
			wg_q   <= wg_d;
			adr_q  <= adr_d;
			wd_q   <= wd_d;
			ws_q   <= ws_d;
			awr_q  <= awr_d;
			wr_q   <= wr_d;
			bv_q   <= bv_d;
			arr_q  <= arr_d;
			rv_q   <= rv_d;
			rd_q   <= rd_d;
			data_q <= data_d;
			ctl_q  <= ctl_d;
		end
	end

	assign awready = awr_q;
	assign wready  = wr_q;
	assign bvalid  = bv_q;
	assign bresp   = RESP_OKAY;
	assign arready = arr_q;
	assign rvalid  = rv_q;
	assign rdata   = rd_q;
	assign rresp   = RESP_OKAY;

	// ------------------------------------------------------------
	// Serial sequencer
	// ------------------------------------------------------------
	ledd_cst_t     st_d;
	logic [7:0]    tmr_q, tmr_d;
	logic [BW-1:0] bit_q, bit_d;
	logic [2:0]    pc_q, pc_d;
	logic [CH-1:0] tx_q, tx_d;
	logic [CH-1:0] rx_d;
	logic          sclk_q, sclk_d, sdi_q, sdi_d, ld_q, ld_d, oen_q, oen_d;
	logic          so1_q, so2_q;

	// One transfer: shift, strobe with pulses, then an enable window.
	always_comb begin
		st_d   = st_q;
		tmr_d  = tmr_q + 8'h01;
		bit_d  = bit_q;
		pc_d   = pc_q;
		tx_d   = tx_q;
		rx_d   = rx_q;
		sclk_d = sclk_q;
		sdi_d  = sdi_q;
		ld_d   = ld_q;
		oen_d  = oen_q;
		case (st_q)
			C_IDLE: begin
				tmr_d = 8'h00;
				if (go) begin
					st_d  = wd_q[CTRL_SKIP] ? C_LDH : C_SHIFT;
					ld_d  = wd_q[CTRL_SKIP];
					bit_d = '0;
					tx_d  = data_q;
					sdi_d = data_q[0];
				end
			end
			C_SHIFT: begin
				if (tmr_q == HALF_END) begin
					tmr_d  = 8'h00;
					sclk_d = ~sclk_q;
					if (!sclk_q) begin
						rx_d = {so2_q, rx_q[CH-1:1]};
					end else if (bit_q == LAST_BIT) begin
						st_d = C_LDH;
						ld_d = 1'b1;
					end else begin
						bit_d = bit_q + 1'b1;
						tx_d  = {tx_q[0], tx_q[CH-1:1]};
						sdi_d = tx_q[1];
					end
				end
			end
			C_LDH: begin
				if (tmr_q == PHASE_END) begin
					tmr_d = 8'h00;
					pc_d  = PULSE_NONE;
					st_d  = (ctl_q[2:0] == PULSE_NONE) ? C_LDL : C_PULSE;
					ld_d  = (ctl_q[2:0] != PULSE_NONE);
				end
			end
			C_PULSE: begin
				if (tmr_q == HALF_END) begin
					tmr_d  = 8'h00;
					sclk_d = ~sclk_q;
					if (sclk_q) begin
						pc_d = pc_q + 3'h1;
						if (pc_d == ctl_q[2:0]) begin
							st_d = C_LDL;
							ld_d = 1'b0;
						end
					end
				end
			end
			C_LDL: begin
				if (tmr_q == PHASE_END) begin
					tmr_d = 8'h00;
					st_d  = C_OEN;
					oen_d = 1'b0;
				end
			end
			C_OEN: begin
				if (tmr_q == OEN_END) begin
					tmr_d = 8'h00;
					st_d  = C_GAP;
					oen_d = 1'b1;
				end
			end
			C_GAP: begin
				if (tmr_q == PHASE_END)
					st_d = C_IDLE;
			end
			default: st_d = C_IDLE;
		endcase
	end

	// Registers of the sequencer, pins and the return synchroniser.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q   <= C_IDLE;
			tmr_q  <= '0;
			bit_q  <= '0;
			pc_q   <= '0;
			tx_q   <= '0;
			rx_q   <= '0;
			sclk_q <= 1'b0;
			sdi_q  <= 1'b0;
			ld_q   <= 1'b0;
			oen_q  <= 1'b1;
			so1_q  <= 1'b0;
			so2_q  <= 1'b0;
		end else if (ce) begin
			st_q   <= st_d;
			tmr_q  <= tmr_d;
			bit_q  <= bit_d;
			pc_q   <= pc_d;
			tx_q   <= tx_d;
			rx_q   <= rx_d;
			sclk_q <= sclk_d;
			sdi_q  <= sdi_d;
			ld_q   <= ld_d;
			oen_q  <= oen_d;
			so1_q  <= link.serial_out_pin;
			so2_q  <= so1_q;
		end
	end

	assign link.serial_clk        = sclk_q;
	assign link.serial_in_pin     = sdi_q;
	assign link.load_strobe       = ld_q;
	assign link.output_enable_low = oen_q;
endmodule

// File: rtl/ledd_device.sv
// LED sink driver: shift register, reports, low-current test, outputs.
`timescale 1ns/1ps
module ledd_device (
	input  wire logic                   aclk,                 // Clock.
	input  wire logic                   aresetn,              // Reset, low.
	input  wire logic                   ce,                   // Clock enable.
	ledd_if.dev                         link,                 // Chain pins.
	input  wire logic [ledd_pkg::CH-1:0] open_fault,          // Open sensed.
	input  wire logic [ledd_pkg::CH-1:0] short_fault,         // Short sensed.
	input  wire logic                   overtemp_flag,        // Die is hot.
	output logic      [ledd_pkg::CH-1:0] sink_on,             // Channel sinks.
	output logic                        reduced_test_current  // Low current.
);
	import ledd_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int SW = 5 + 2 * CH;
	// Idle levels of the pins: only the enable idles high. A low reset
	// value here would show a false enable rise just after reset.
	localparam logic [SW-1:0] S_IDLE = {4'h1, {(SW - 4){1'b0}}};
	logic [SW-1:0] s1_q;
	logic [SW-1:0] s2_q;
	logic [3:0]    p_q;
	logic [SW-1:0] raw;
	assign raw = {link.serial_clk, link.serial_in_pin, link.load_strobe,
		link.output_enable_low, overtemp_flag, open_fault, short_fault};

	// Two flops on every pin; edges are found on the second stage only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= S_IDLE;
			s2_q <= S_IDLE;
			p_q  <= S_IDLE[SW-1:SW-4];
		end else if (ce) begin
			s1_q <= raw;
			s2_q <= s1_q;
			p_q  <= s2_q[SW-1:SW-4];
		end
	end

	logic          s_clk;
	logic          s_sdi;
	logic          s_ld;
	logic          s_oen;
	logic          s_hot;
	logic [CH-1:0] s_open;
	logic [CH-1:0] s_short;
	assign s_clk   = s2_q[SW-1];
	assign s_sdi   = s2_q[SW-2];
	assign s_ld    = s2_q[SW-3];
	assign s_oen   = s2_q[SW-4];
	assign s_hot   = s2_q[2*CH];
	assign s_open  = s2_q[2*CH-1:CH];
	assign s_short = s2_q[CH-1:0];

	logic clk_rise;
	logic ld_rise;
	logic ld_fall;
	logic oen_rise;
	logic oen_fall;
	assign clk_rise = s_clk & ~p_q[3];
	assign ld_rise  = s_ld & ~p_q[1];
	assign ld_fall  = ~s_ld & p_q[1];
	assign oen_rise = s_oen & ~p_q[0];
	assign oen_fall = ~s_oen & p_q[0];

	// ------------------------------------------------------------
	// Shift, display, report and test state
	// ------------------------------------------------------------
	logic [CH-1:0] sr_q, sr_d;
	logic [CH-1:0] disp_q, disp_d;
	logic [CH-1:0] save_q, save_d;
	logic [CH-1:0] shown_q, shown_d;
	logic [CH-1:0] open_q, open_d;
	logic [CH-1:0] short_q, short_d;
	logic          temp_q, temp_d;
	logic [2:0]    cnt_q, cnt_d;
	ledd_rep_t     rep_q, rep_d;
	ledd_lc_t      lc_q, lc_d;
	logic          rtc_q, rtc_d;
	logic [CH-1:0] pat;

	// Word copied into the shift register for the selected report.
	function automatic logic [CH-1:0] rep_word(input ledd_rep_t sel,
		input logic [CH-1:0] op, input logic [CH-1:0] sh, input logic t);
		case (sel)
			REP_OPEN:  rep_word = op;
			REP_SHORT: rep_word = sh;
			default: begin
				rep_word           = ALL_ONES;
				rep_word[TEMP_BIT] = t;
			end
		endcase
	endfunction

	// Pattern that the outputs would take at the next enable fall.
	always_comb begin
		case (lc_q)
			LC_ARMED: pat = ALL_ONES;
			LC_TEST:  pat = ALL_ONES;
			LC_HOLD:  pat = save_q;
			default:  pat = disp_q;
		endcase
	end

	// Next state of the serial, report and diagnosis logic.
	always_comb begin
		sr_d    = sr_q;
		disp_d  = disp_q;
		save_d  = save_q;
		shown_d = shown_q;
		open_d  = open_q;
		short_d = short_q;
		temp_d  = temp_q;
		cnt_d   = cnt_q;
		rep_d   = rep_q;
		lc_d    = lc_q;
		rtc_d   = rtc_q;
		// Pulses while the strobe is high are counted, never shifted.
		if (clk_rise) begin
			if (s_ld) begin
				if (cnt_q != PULSE_MAX)
					cnt_d = cnt_q + 3'h1;
			end else begin
				sr_d = {s_sdi, sr_q[CH-1:1]};
			end
		end
		if (ld_rise) begin
			disp_d = sr_q;
			cnt_d  = PULSE_NONE;
		end
		if (oen_fall)
			shown_d = pat;
		// Results are taken at every enable rise; dark channels read one.
		if (oen_rise) begin
			open_d  = ~shown_q | ~s_open;
			short_d = ~shown_q | ~s_short;
			temp_d  = ~s_hot;
		end
		if (ld_fall) begin
			case (cnt_q)
				PULSE_OPEN:  rep_d = REP_OPEN;
				PULSE_SHORT: rep_d = REP_SHORT;
				default:     rep_d = REP_TEMP;
			endcase
			sr_d = rep_word(rep_d, open_q, short_q, temp_q);
			if (cnt_q == PULSE_LCD && lc_q == LC_OFF) begin
				lc_d   = LC_ARMED;
				save_d = disp_q;
			end
		end
		case (lc_q)
			LC_ARMED: begin
				if (oen_fall) begin
					lc_d  = LC_TEST;
					rtc_d = 1'b1;
				end
			end
			LC_TEST: begin
				if (oen_rise) begin
					lc_d  = LC_HOLD;
					rtc_d = 1'b0;
				end
			end
			LC_HOLD: begin
				if (!s_ld && !s_oen) begin
					lc_d   = LC_OFF;
					disp_d = save_q;
				end
			end
			// Idle: only the three-pulse strobe fall above arms the test.
			LC_OFF: ;
			default: lc_d = LC_OFF;
		endcase
	end

	// Registers of the serial and diagnosis logic.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sr_q    <= '0;
			disp_q  <= '0;
			save_q  <= '0;
			shown_q <= '0;
			open_q  <= ALL_ONES;
			short_q <= ALL_ONES;
			temp_q  <= 1'b1;
			cnt_q   <= PULSE_NONE;
			rep_q   <= REP_TEMP;
			lc_q    <= LC_OFF;
			rtc_q   <= 1'b0;
		end else if (ce) begin
			sr_q    <= sr_d;
			disp_q  <= disp_d;
			save_q  <= save_d;
			shown_q <= shown_d;
			open_q  <= open_d;
			short_q <= short_d;
			temp_q  <= temp_d;
			cnt_q   <= cnt_d;
			rep_q   <= rep_d;
			lc_q    <= lc_d;
			rtc_q   <= rtc_d;
		end
	end

	assign link.serial_out_pin = sr_q[0];
	assign reduced_test_current = rtc_q;

	// ------------------------------------------------------------
	// Staggered output turn-on
	// ------------------------------------------------------------
	logic [DLY_W-1:0] dly_q, dly_d;
	logic [CH-1:0]    sink_d;
	logic [CH-1:0]    sink_q;

	// Time since the enable fell; turn-off is never delayed.
	always_comb begin
		if (s_oen)
			dly_d = '0;
		else if (dly_q == DLY_W'(DLY_MAX))
			dly_d = dly_q;
		else
			dly_d = dly_q + 4'h1;
	end

	// Each channel waits its own whole number of cycles to limit inrush.
	for (genvar g = 0; g < CH; g++) begin : g_stagger
		localparam logic [DLY_W-1:0] DLY = DLY_W'(dly_cyc(g));
		assign sink_d[g] = ~s_oen & shown_d[g] & (dly_q >= DLY);
	end

	// Registers of the output stage.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dly_q  <= '0;
			sink_q <= '0;
		end else if (ce) begin
			dly_q  <= dly_d;
			sink_q <= sink_d;
		end
	end

	assign sink_on = sink_q;
endmodule

// File: rtl/ledd_if.sv
// Serial chain pins shared by the driver and its controller.
`timescale 1ns/1ps
interface ledd_if;
	logic serial_clk;
	logic serial_in_pin;
	logic serial_out_pin;
	logic load_strobe;
	logic output_enable_low;
	modport dev (
		input  serial_clk,
		input  serial_in_pin,
		input  load_strobe,
		input  output_enable_low,
		output serial_out_pin
	);
	modport ctrl (
		output serial_clk,
		output serial_in_pin,
		output load_strobe,
		output output_enable_low,
		input  serial_out_pin
	);
endinterface

// File: rtl/ledd_pkg.sv
// Shared constants and types for the LED sink driver and its controller.
package ledd_pkg;
	// Channel count and the width of one device's shift register.
	localparam int CH = 16;
	// System clock period and documented times.
	localparam int CLK_NS     = 100;
	localparam int STEP_NS    = 20;
	localparam int OEN_MIN_NS = 2000;
	// Least enable time for the low-current test, rounded up.
	localparam int OEN_CYC  = (OEN_MIN_NS + CLK_NS - 1) / CLK_NS;
	// Latency of a two-flop synchroniser.
	localparam int SYNC_LAT = 2;
	// Turn-on delay counter width and its ceiling in cycles.
	localparam int DLY_W   = 4;
	localparam int DLY_MAX = ((CH - 1) * STEP_NS + CLK_NS - 1) / CLK_NS;
	// Pulse counts decoded while the load strobe is high.
	localparam logic [2:0] PULSE_NONE  = 3'h0;
	localparam logic [2:0] PULSE_OPEN  = 3'h1;
	localparam logic [2:0] PULSE_SHORT = 3'h2;
	localparam logic [2:0] PULSE_LCD   = 3'h3;
	localparam logic [2:0] PULSE_MAX   = 3'h7;
	// Pattern and report values.
	localparam logic [CH-1:0] ALL_ONES = 16'hFFFF;
	localparam int            TEMP_BIT = 0;
	// Controller register map (byte offsets) and fields.
	localparam int         ADDR_W     = 4;
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_DATA   = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_RX     = 4'hC;
	localparam int         CTRL_SKIP  = 3;
	localparam int         STAT_BUSY  = 0;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	// Turn-on delay of channel i in whole cycles, rounded up.
	function automatic int dly_cyc(input int i);
		dly_cyc = (i * STEP_NS + CLK_NS - 1) / CLK_NS;
	endfunction
	typedef enum logic [1:0] {REP_TEMP, REP_OPEN, REP_SHORT} ledd_rep_t;
	typedef enum logic [1:0] {LC_OFF, LC_ARMED, LC_TEST, LC_HOLD} ledd_lc_t;
	typedef enum logic [2:0] {
		C_IDLE, C_SHIFT, C_LDH, C_PULSE, C_LDL, C_OEN, C_GAP
	} ledd_cst_t;
endpackage

// File: testbench/led_driver_diag_control_bench.sv
// Self-checking bench: AXI4-Lite controller driving one LED driver.
`timescale 1ns/1ps
module led_driver_diag_control_bench;
	import ledd_pkg::*;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic              awvalid = 1'b0;
	logic              awready;
	logic [31:0]       wdata = '0;
	logic [3:0]        wstrb = '0;
	logic              wvalid = 1'b0;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready = 1'b0;
	logic [ADDR_W-1:0] araddr = '0;
	logic              arvalid = 1'b0;
	logic              arready;
	logic [31:0]       rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready = 1'b0;
	logic [CH-1:0]     open_fault = '0;
	logic [CH-1:0]     short_fault = '0;
	logic              overtemp_flag = 1'b0;
	logic [CH-1:0]     sink_on;
	logic              reduced_test_current;
	int                fails = 0;
	int                comparisons = 0;
	// 10 MHz system clock.
	always #50 aclk = ~aclk;
	// -------------------------------------------------------------
	// Design, link and checker
	// -------------------------------------------------------------
	ledd_if link_if ();
	ledd_device ledd_device_inst (.aclk(aclk), .aresetn(aresetn),
		.ce(1'b1), .link(link_if.dev), .open_fault(open_fault),
		.short_fault(short_fault), .overtemp_flag(overtemp_flag),
		.sink_on(sink_on), .reduced_test_current(reduced_test_current));
	ledd_ctrl #(.CHAIN(1), .HALF(4)) ledd_ctrl_inst (.aclk(aclk),
		.aresetn(aresetn), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.link(link_if.ctrl));
	ledd_monitor ledd_monitor_inst (.aclk(aclk), .aresetn(aresetn),
		.serial_clk(link_if.serial_clk),
		.serial_in_pin(link_if.serial_in_pin),
		.serial_out_pin(link_if.serial_out_pin),
		.load_strobe(link_if.load_strobe),
		.output_enable_low(link_if.output_enable_low));
	// -------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One comparison; four-state so an unknown never matches.
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// A wait that ran out counts as a mismatch and closes the run.
	task automatic tmo;
		fails++;
		finish_test();
	endtask
	// Lets an edge land so that outputs are settled when looked at.
	task automatic tick;
		@(posedge aclk);
		#1;
	endtask
	// Write: address and data offered together, each dropped when taken.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				chk("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
				break;
			end
		end
		bready <= 1'b0;
		if (n == 100) tmo();
	endtask
	// Read: rready held until rvalid is seen, data taken at that edge.
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				chk("rresp", {30'h0, rresp}, {30'h0, RESP_OKAY});
				break;
			end
		end
		d = rdata;
		rready <= 1'b0;
		if (n == 100) tmo();
	endtask
	// One chain transfer: data, order, wait for idle, fetch shifted-out word.
	task automatic xfer(input logic [15:0] d, input logic [3:0] c,
		output logic [15:0] rx);
		logic [31:0] v;
		int          n;
		wr(REG_DATA, {16'h0, d});
		wr(REG_CTRL, {28'h0, c});
		v = 32'h1;
		for (n = 0; n < 100 && v[STAT_BUSY] !== 1'b0; n++)
			rd(REG_STATUS, v);
		if (n == 100) tmo();
		rd(REG_RX, v);
		rx = v[15:0];
	endtask
	// Waits for the enable to fall, then checks the shown pattern.
	task automatic shown(input logic [15:0] e);
		int n;
		for (n = 0; n < 600 && link_if.output_enable_low !== 1'b0; n++)
			tick();
		if (n == 600) tmo();
		repeat (10) tick();
		chk("sink_on", {16'h0, sink_on}, {16'h0, e});
	endtask
	// Channels come on in four steps; a higher index never comes on earlier.
	task automatic stagger;
		logic [15:0] st [4];
		int          n;
		st = '{16'h0001, 16'h003F, 16'h07FF, 16'hFFFF};
		for (n = 0; n < 600 && sink_on === 16'h0; n++)
			tick();
		if (n == 600) tmo();
		for (n = 0; n < 4; n++) begin
			chk("turn_on", {16'h0, sink_on}, {16'h0, st[n]});
			tick();
		end
	endtask
	// Low-current test: reduced current and all channels while enabled.
	task automatic low_test;
		int n;
		for (n = 0; n < 600 && reduced_test_current !== 1'b1; n++)
			tick();
		if (n == 600) tmo();
		chk("enable", {31'h0, link_if.output_enable_low}, 32'h0);
		repeat (8) tick();
		chk("pattern", {16'h0, sink_on}, 32'h0000FFFF);
		for (n = 0; n < 100 && reduced_test_current !== 1'b0; n++)
			tick();
		if (n == 100) tmo();
		chk("end", {31'h0, link_if.output_enable_low}, 32'h1);
	endtask
	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	// Faults on channels 4, 5, 8 and 14 show which channels are judged.
	initial begin
		logic [15:0] rx;
		logic [31:0] v;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		overtemp_flag <= 1'b1;
		open_fault <= 16'h0030;
		short_fault <= 16'h4100;
		tick();
		tick();
		rd(4'h2, v);
		chk("unmapped", v, 32'h0);
		fork
			xfer(16'hFFFF, 4'h0, rx);
			stagger();
		join
		fork
			xfer(16'h400F, 4'h1, rx);
			shown(16'h400F);
		join
		chk("temp", {16'h0, rx}, 32'h0000FFFF);
		xfer(16'h1234, 4'h2, rx);
		chk("open", {16'h0, rx}, 32'h0000FFCF);
		fork
			xfer(16'h5A5A, 4'h3, rx);
			low_test();
		join
		chk("short", {16'h0, rx}, 32'h0000BFFF);
		fork
			xfer(16'h0000, 4'hA, rx);
			shown(16'h5A5A);
		join
		xfer(16'h0000, 4'h4, rx);
		chk("after", {16'h0, rx}, 32'h0000BEFF);
		// Four pulses pick no report, so the hot die shows in bit zero.
		xfer(16'h0000, 4'h0, rx);
		chk("hot", {16'h0, rx}, 32'h0000FFFE);
		finish_test();
	end
endmodule

// File: testbench/ledd_monitor.sv
// Checker on the serial chain between the controller and the driver.
`timescale 1ns/1ps
module ledd_monitor (
	input wire logic aclk,              // Clock.
	input wire logic aresetn,           // Reset, low.
	input wire logic serial_clk,        // Chain clock.
	input wire logic serial_in_pin,     // Data to driver.
	input wire logic serial_out_pin,    // Data from driver.
	input wire logic load_strobe,       // Load strobe.
	input wire logic output_enable_low  // Enable, low.
);
	// Shortest enable pulse, in cycles, that the LED test may be given.
	localparam int OEN_LOW = ledd_pkg::OEN_CYC;
	logic [7:0] low_q;
	logic [7:0] low_d;
	// -------------------------------------------------------------
	// Helper logic
	// -------------------------------------------------------------
	// Counts enable-low cycles; it saturates so a long pulse never wraps.
	always_comb begin
		low_d = low_q;
		if (output_enable_low)
			low_d = 8'h00;
		else if (low_q != 8'hFF)
			low_d = low_q + 8'h01;
	end
	// Registers the count; cleared in reset.
	always_ff @(posedge aclk) begin
		low_q <= aresetn ? low_d : 8'h00;
	end
	// -------------------------------------------------------------
	// Properties
	// -------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// The strobe drops, then the enable follows after a short wait.
	sequence s_ld_down;
		$fell(load_strobe);
	endsequence
	sequence s_enable_wait;
		output_enable_low[*6] ##[1:4] !output_enable_low;
	endsequence
	a_sdi_held_rise: assert property (
		$rose(serial_clk) |-> $stable(serial_in_pin))
		else $error("serial data moved at a clock rise");
	a_clk_high_len: assert property (
		$rose(serial_clk) |=> serial_clk[*3] ##1 !serial_clk)
		else $error("serial clock high time wrong");
	a_ld_clk_low: assert property (
		$rose(load_strobe) |-> !serial_clk)
		else $error("strobe rose with serial clock high");
	a_enable_order: assert property (
		s_ld_down |-> s_enable_wait)
		else $error("enable not given after strobe fall");
	a_enable_len: assert property (
		$rose(output_enable_low) |-> low_q >= OEN_LOW)
		else $error("enable low time too short");
	a_quiet_enabled: assert property (
		!output_enable_low |-> !serial_clk && !load_strobe)
		else $error("chain active while enabled");
	a_gap_after: assert property (
		$rose(output_enable_low)
		|-> (output_enable_low && !load_strobe)[*8])
		else $error("no gap after enable");
	a_sdo_quiet: assert property (
		(!serial_clk && !load_strobe)[*8] |-> $stable(serial_out_pin))
		else $error("serial out moved without a clock");
endmodule
